/* File: shared/stc_pkg.sv */
/*
 * Shared constants and carrier types for the scan timer/counter block.
 * Assumes a single clock domain and a scan strobe from the sequencer.
 */
package stc_pkg;

    localparam int STC_VAL_W    = 16;
    localparam int STC_TICK_W   = 16;
    localparam logic [15:0] STC_ZERO = 16'h0000;
    localparam logic [15:0] STC_ONE  = 16'h0001;
    localparam logic [15:0] STC_MAX  = 16'hFFFF;
    localparam int STC_CLK_HZ   = 25000000;
    localparam int STC_BASE_US  = 1000;
    localparam int STC_BASE_CYC = (STC_CLK_HZ / 1000000) * STC_BASE_US;

    // Sampled inputs of all six functions for one scan.
    typedef struct packed {
        logic rtrg_in;
        logic mono_in;
        logic up_cnt;
        logic up_rst;
        logic dn_cnt;
        logic dn_rst;
        logic ud_up;
        logic ud_dn;
        logic ud_rst;
        logic ring_cnt;
        logic ring_rst;
    } stc_in_t;

    // Presets of all six functions.
    typedef struct packed {
        logic [15:0] rtrg;
        logic [15:0] mono;
        logic [15:0] up;
        logic [15:0] dn;
        logic [15:0] ud;
        logic [15:0] ring;
    } stc_preset_t;

    // Output flags of all six functions.
    typedef struct packed {
        logic rtrg;
        logic mono;
        logic up;
        logic dn;
        logic ud;
        logic ring;
    } stc_flag_t;

    typedef enum logic [1:0] {
        STC_T_IDLE = 2'b01,
        STC_T_RUN  = 2'b10
    } stc_tstate_t;

endpackage

/* File: design/stc_edge.sv */
/*
 * Scan-rate sampler with off-to-on edge detection for a bundle of inputs.
 * Assumes inputs synchronous to clk and a one-cycle scan strobe.
 */
`timescale 1ns/1ps
module stc_edge #(
    parameter int WIDTH = 11
) (
    // Clock, reset and enable.
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Sampling.
    input  wire logic             scan,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] level_ff,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] prev_ff;

    // Refuse an empty bundle at elaboration rather than at run time.
    if (WIDTH < 1) begin : g_width_chk
        $error("stc_edge: WIDTH must be positive");
    end

    // Edge compares this scan's sample with the previous scan's.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_ff <= '0;
            prev_ff  <= '0;
        end else if (ce && scan) begin
            prev_ff  <= level_ff;
            level_ff <= din;
        end
    end

    // Only off-to-on counts; steady and falling levels give nothing.
    assign rise = level_ff & ~prev_ff;
endmodule

/* File: design/stc_top.sv */
/*
 * Scan-evaluated timers and counters: retriggerable and plain one-shot
 * down-timers, up, down, up-down and ring counters.
 * Assumes the sequencer pulses scan once per program scan, holds
 * run_start high for one scan when entering run mode, and drives all
 * inputs synchronous to clk.
 */
`timescale 1ns/1ps
module stc_top
    import stc_pkg::*;
#(
    parameter int BASE_CYC = STC_BASE_CYC
) (
    // Clock, reset, enable.
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // Scan control.
    input  wire logic                scan,
    input  wire logic                run_start,
    // Conditions and presets.
    input  wire stc_pkg::stc_in_t     cond,
    input  wire stc_pkg::stc_preset_t preset,
    // Results.
    output stc_pkg::stc_flag_t        flag_ff,
    output stc_pkg::stc_preset_t      value_ff,
    output logic                      base_tick
);
    import stc_pkg::*;

    // Refuse a time base that the counter cannot count.
    if (BASE_CYC < 1) begin : g_base_chk
        $error("stc_top: BASE_CYC must be positive");
    end

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == STC_MAX) ? v : v + STC_ONE;
    endfunction

    function automatic logic [15:0] sat_dec(input logic [15:0] v);
        sat_dec = (v == STC_ZERO) ? v : v - STC_ONE;
    endfunction

    stc_in_t lvl;
    stc_in_t rise;
    logic    upd;

    stc_edge #(.WIDTH($bits(stc_in_t))) u_edge (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .scan     (scan),
        .din      (cond),
        .level_ff (lvl),
        .rise     (rise)
    );

    // Results are evaluated one cycle after the scan sample settles.
    logic upd_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) upd_ff <= 1'b0;
        else if (ce) upd_ff <= scan;
    end
    assign upd = ce && upd_ff;

    ////////////////////////////////////////////////////////////////////////
    // Time base: timers decrement at a fixed base, checked only at scan
    // evaluation, so a flag may lag by up to one scan.
    logic [31:0] base_cnt_ff;
    logic        base_pend_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_cnt_ff <= 32'h00000000;
        end else if (ce) begin
            if (base_cnt_ff == 32'(BASE_CYC - 1)) base_cnt_ff <= 32'h00000000;
            else base_cnt_ff <= base_cnt_ff + 32'h00000001;
        end
    end
    assign base_tick = ce && (base_cnt_ff == 32'(BASE_CYC - 1));

    // Pending base tick is consumed by the next scan evaluation.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) base_pend_ff <= 1'b0;
        else if (ce) begin
            if (base_tick) base_pend_ff <= 1'b1;
            else if (upd) base_pend_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Retriggerable one-shot.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_ff.rtrg <= STC_ZERO;
            flag_ff.rtrg  <= 1'b0;
        end else if (upd) begin
            if (rise.rtrg_in) begin
                // Reload even mid-count.
                value_ff.rtrg <= preset.rtrg;
                flag_ff.rtrg  <= (preset.rtrg != STC_ZERO);
            end else if (flag_ff.rtrg && base_pend_ff) begin
                value_ff.rtrg <= sat_dec(value_ff.rtrg);
                flag_ff.rtrg  <= (value_ff.rtrg > STC_ONE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Non-retriggerable one-shot.
    stc_tstate_t mono_st_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mono_st_ff    <= STC_T_IDLE;
            value_ff.mono <= STC_ZERO;
            flag_ff.mono  <= 1'b0;
        end else if (upd) begin
            case (mono_st_ff)
                STC_T_IDLE: begin
                    if (rise.mono_in && preset.mono != STC_ZERO) begin
                        mono_st_ff    <= STC_T_RUN;
                        value_ff.mono <= preset.mono;
                        flag_ff.mono  <= 1'b1;
                    end
                end
                STC_T_RUN: begin
                    // Input changes are not looked at here.
                    if (base_pend_ff) begin
                        value_ff.mono <= sat_dec(value_ff.mono);
                        if (value_ff.mono <= STC_ONE) begin
                            mono_st_ff   <= STC_T_IDLE;
                            flag_ff.mono <= 1'b0;
                        end
                    end
                end
                default: mono_st_ff <= STC_T_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Up counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_ff.up <= STC_ZERO;
            flag_ff.up  <= 1'b0;
        end else if (upd) begin
            if (lvl.up_rst) begin
                // Reset wins over a count edge.
                value_ff.up <= STC_ZERO;
                flag_ff.up  <= 1'b0;
            end else begin
                if (rise.up_cnt) value_ff.up <= sat_inc(value_ff.up);
                flag_ff.up <= ((rise.up_cnt ? sat_inc(value_ff.up)
                                            : value_ff.up) >= preset.up);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Down counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_ff.dn <= STC_ZERO;
            flag_ff.dn  <= 1'b0;
        end else if (upd) begin
            if (run_start || lvl.dn_rst) begin
                // Load from preset on run entry or reset.
                value_ff.dn <= preset.dn;
                flag_ff.dn  <= (preset.dn == STC_ZERO);
            end else if (rise.dn_cnt) begin
                value_ff.dn <= sat_dec(value_ff.dn);
                flag_ff.dn  <= (sat_dec(value_ff.dn) == STC_ZERO);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Up-down counter.
    logic [15:0] nxt_ud;
    always_comb begin
        nxt_ud = value_ff.ud;
        if (rise.ud_up && !rise.ud_dn) nxt_ud = sat_inc(value_ff.ud);
        if (rise.ud_dn && !rise.ud_up) nxt_ud = sat_dec(value_ff.ud);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_ff.ud <= STC_ZERO;
            flag_ff.ud  <= 1'b0;
        end else if (upd) begin
            if (lvl.ud_rst) begin
                value_ff.ud <= STC_ZERO;
                flag_ff.ud  <= (preset.ud == STC_ZERO);
            end else begin
                value_ff.ud <= nxt_ud;
                flag_ff.ud  <= (nxt_ud >= preset.ud);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_ff.ring <= STC_ZERO;
            flag_ff.ring  <= 1'b0;
        end else if (upd) begin
            if (lvl.ring_rst) begin
                value_ff.ring <= STC_ZERO;
                flag_ff.ring  <= 1'b0;
            end else if (rise.ring_cnt) begin
                if (flag_ff.ring) begin
                    value_ff.ring <= STC_ZERO;
                    flag_ff.ring  <= 1'b0;
                end else begin
                    value_ff.ring <= sat_inc(value_ff.ring);
                    flag_ff.ring  <= (sat_inc(value_ff.ring) >= preset.ring);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_up_reset_clear: assert property (
        @(posedge clk) disable iff (rst)
        (upd && lvl.up_rst) |=> (value_ff.up == STC_ZERO && !flag_ff.up))
        else $error("up counter not cleared by reset");

    a_up_flag_cmp: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !lvl.up_rst)
        |=> (flag_ff.up == (value_ff.up >= $past(preset.up))))
        else $error("up flag disagrees with preset");

    a_rtrg_reload: assert property (
        @(posedge clk) disable iff (rst)
        (upd && rise.rtrg_in) |=> (value_ff.rtrg == $past(preset.rtrg)))
        else $error("retrigger did not reload");

    a_rtrg_step: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !rise.rtrg_in && flag_ff.rtrg && base_pend_ff)
        |=> (value_ff.rtrg == $past(value_ff.rtrg) - STC_ONE))
        else $error("retrigger timer did not step down");

    // A running one-shot moves only by the time base, whatever its input.
    a_mono_hold: assert property (
        @(posedge clk) disable iff (rst)
        (upd && mono_st_ff == STC_T_RUN)
        |=> (value_ff.mono
             == $past(value_ff.mono) - {15'h0000, $past(base_pend_ff)}))
        else $error("one-shot reacted to input while running");

    a_dn_load: assert property (
        @(posedge clk) disable iff (rst)
        (upd && run_start) |=> (value_ff.dn == $past(preset.dn)))
        else $error("down counter not loaded on run entry");

    a_dn_step: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !run_start && !lvl.dn_rst && rise.dn_cnt
         && value_ff.dn != STC_ZERO)
        |=> (value_ff.dn == $past(value_ff.dn) - STC_ONE))
        else $error("down counter did not step by one");

    a_dn_zero_flag: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !run_start && !lvl.dn_rst && rise.dn_cnt)
        |=> (flag_ff.dn == (value_ff.dn == STC_ZERO)))
        else $error("down flag disagrees with zero");

    a_ud_step_up: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !lvl.ud_rst && rise.ud_up && !rise.ud_dn
         && value_ff.ud != STC_MAX)
        |=> (value_ff.ud == $past(value_ff.ud) + STC_ONE))
        else $error("up-down counter did not step up");

    a_ud_flag_cmp: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !lvl.ud_rst)
        |=> (flag_ff.ud == (value_ff.ud >= $past(preset.ud))))
        else $error("up-down flag wrong");

    a_no_edge_hold: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !rise.up_cnt && !lvl.up_rst) |=> $stable(value_ff.up))
        else $error("up counter moved without an edge");

    a_ring_flag_set: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !lvl.ring_rst && rise.ring_cnt && !flag_ff.ring)
        |=> (flag_ff.ring == (value_ff.ring >= $past(preset.ring))))
        else $error("ring flag disagrees with preset");

    a_ring_wrap: assert property (
        @(posedge clk) disable iff (rst)
        (upd && !lvl.ring_rst && rise.ring_cnt && flag_ff.ring)
        |=> (value_ff.ring == STC_ZERO && !flag_ff.ring))
        else $error("ring counter did not clear");

    // With the enable low no sample is taken and nothing may move.
    a_ce_freeze: assert property (
        @(posedge clk) disable iff (rst)
        !ce |=> ($stable(value_ff) && $stable(flag_ff)))
        else $error("state moved while the enable was low");
endmodule

/* File: bench/stc_seq_model.sv */
/*
 * Sequence program model: issues the scan strobe and the input levels
 * that the scanned program presents to the timers and counters.
 * Assumes one free-running clk; all outputs change on its falling edge.
 */
`timescale 1ns/1ps
module stc_seq_model #(
    parameter int SCAN_CYC = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels wanted for the coming scan.
    input  wire stc_pkg::stc_in_t req,
    // Towards the block.
    output logic                  scan,
    output stc_pkg::stc_in_t      cond
);
    import stc_pkg::*;

    int cnt;

    ////////////////////////////////////////////////////////////////////////
    // Levels move only together with a strobe, so every level is held for
    // a whole scan period and no transition can fall between two samples.
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            scan <= 1'b0;
            cond <= '0;
        end else begin
            cnt <= (cnt == SCAN_CYC - 1) ? 0 : cnt + 1;
            scan <= (cnt == SCAN_CYC - 1);
            if (cnt == SCAN_CYC - 1) begin
                cond <= req;
            end
        end
    end
endmodule

/* File: bench/scan_timers_counters_tb_top.sv */
/*
 * Self-checking testbench for the scan timer/counter block.
 * Assumes the sequence model supplies scan and cond; presets, ce and
 * run_start are driven here on the falling edge of clk.
 */
`timescale 1ns/1ps
module scan_timers_counters_tb_top;
    import stc_pkg::*;

    localparam stc_in_t K_RT   = 11'h400;
    localparam stc_in_t K_MO   = 11'h200;
    localparam stc_in_t K_UP   = 11'h100;
    localparam stc_in_t K_URST = 11'h080;
    localparam stc_in_t K_DN   = 11'h040;
    localparam stc_in_t K_UDU  = 11'h010;
    localparam stc_in_t K_UDD  = 11'h008;
    localparam stc_in_t K_RING = 11'h002;
    localparam stc_in_t K_DRST = 11'h020;
    localparam stc_in_t K_UDR  = 11'h004;
    localparam stc_in_t K_RRST = 11'h001;
    localparam int      K_BASE  = 4;
    localparam int      K_TICKS = 10;

    logic        clk;
    logic        rst;
    logic        ce;
    logic        run_start;
    logic        scan;
    stc_in_t     req;
    stc_in_t     cond;
    stc_preset_t preset;
    stc_preset_t value_ff;
    stc_flag_t   flag_ff;
    logic        base_tick;
    int          fail_count = 0;
    int          num_checks = 0;

    stc_seq_model #(.SCAN_CYC(4)) i_seq (.clk(clk), .rst(rst), .req(req),
        .scan(scan), .cond(cond));

    // A short time base keeps the timer scenarios to a few dozen scans.
    stc_top #(.BASE_CYC(K_BASE)) i_dut (.clk(clk), .rst(rst), .ce(ce),
        .scan(scan), .run_start(run_start), .cond(cond), .preset(preset),
        .flag_ff(flag_ff), .value_ff(value_ff), .base_tick(base_tick));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp,
                            input logic got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Hands levels to the model and returns once that scan is evaluated.
    task automatic apply(input stc_in_t c);
        req = c;
        @(posedge scan);
        @(negedge clk);
        @(negedge clk);
    endtask

    task automatic pulse(input stc_in_t c);
        apply(c);
        apply('0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // The time base pulses once every K_BASE enabled cycles and never
    // while the enable is low; an unknown pulse is counted as a pulse.
    task automatic test_base();
        int ticks;
        ticks = 0;
        repeat (K_TICKS * K_BASE) begin
            @(negedge clk);
            if (base_tick !== 1'b0) ticks++;
        end
        chk_val("base ticks", 16'(K_TICKS), 16'(ticks));
        ce = 1'b0;
        ticks = 0;
        repeat (K_TICKS * K_BASE) begin
            @(negedge clk);
            if (base_tick !== 1'b0) ticks++;
        end
        ce = 1'b1;
        chk_val("base ticks frozen", 16'h0000, 16'(ticks));
    endtask

    task automatic test_up();
        repeat (3) apply(K_UP);
        chk_val("up value", 16'h0001, value_ff.up);
        apply('0);
        pulse(K_UP);
        chk_flag("up flag", 1'b0, flag_ff.up);
        pulse(K_UP);
        chk_val("up value", 16'h0003, value_ff.up);
        chk_flag("up flag", 1'b1, flag_ff.up);
        apply(K_UP | K_URST);
        chk_val("up value", 16'h0000, value_ff.up);
        chk_flag("up flag", 1'b0, flag_ff.up);
        apply('0);
    endtask

    task automatic test_down();
        run_start = 1'b1;
        apply('0);
        run_start = 1'b0;
        chk_val("down value", 16'h0002, value_ff.dn);
        chk_flag("down flag", 1'b0, flag_ff.dn);
        pulse(K_DN);
        chk_val("down value", 16'h0001, value_ff.dn);
        pulse(K_DN);
        chk_val("down value", 16'h0000, value_ff.dn);
        chk_flag("down flag", 1'b1, flag_ff.dn);
        pulse(K_DN);
        chk_val("down value", 16'h0000, value_ff.dn);
        apply(K_DN | K_DRST);
        chk_val("down value", 16'h0002, value_ff.dn);
        chk_flag("down flag", 1'b0, flag_ff.dn);
        apply('0);
    endtask

    task automatic test_updown();
        pulse(K_UDU);
        chk_val("updown value", 16'h0001, value_ff.ud);
        chk_flag("updown flag", 1'b0, flag_ff.ud);
        pulse(K_UDU);
        chk_flag("updown flag", 1'b1, flag_ff.ud);
        pulse(K_UDD);
        chk_val("updown value", 16'h0001, value_ff.ud);
        chk_flag("updown flag", 1'b0, flag_ff.ud);
        pulse(K_UDU | K_UDD);
        chk_val("updown value", 16'h0001, value_ff.ud);
        apply(K_UDU | K_UDR);
        chk_val("updown value", 16'h0000, value_ff.ud);
        chk_flag("updown flag", 1'b0, flag_ff.ud);
        apply('0);
    endtask

    task automatic test_ring();
        ce = 1'b0;
        pulse(K_RING);
        ce = 1'b1;
        chk_val("ring value", 16'h0000, value_ff.ring);
        pulse(K_RING);
        chk_flag("ring flag", 1'b0, flag_ff.ring);
        pulse(K_RING);
        chk_val("ring value", 16'h0002, value_ff.ring);
        chk_flag("ring flag", 1'b1, flag_ff.ring);
        pulse(K_RING);
        chk_val("ring value", 16'h0000, value_ff.ring);
        chk_flag("ring flag", 1'b0, flag_ff.ring);
        pulse(K_RING);
        apply(K_RING | K_RRST);
        chk_val("ring value", 16'h0000, value_ff.ring);
        chk_flag("ring flag", 1'b0, flag_ff.ring);
        apply('0);
    endtask

    task automatic test_timers();
        apply(K_RT | K_MO);
        chk_val("retrig value", 16'h0008, value_ff.rtrg);
        chk_flag("oneshot flag", 1'b1, flag_ff.mono);
        chk_flag("retrig flag", 1'b1, flag_ff.rtrg);
        repeat (3) apply('0);
        chk_flag("retrig running", 1'b1, value_ff.rtrg < 16'h0008);
        apply(K_RT | K_MO);
        chk_val("retrig value", 16'h0008, value_ff.rtrg);
        chk_flag("oneshot ignore", 1'b1, value_ff.mono < 16'h0008);
        // Expiry is allowed to lag, so a generous number of scans is given.
        repeat (12) apply('0);
        chk_flag("retrig flag", 1'b0, flag_ff.rtrg);
        chk_flag("oneshot flag", 1'b0, flag_ff.mono);
        chk_val("oneshot value", 16'h0000, value_ff.mono);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        run_start = 1'b0;
        req = '0;
        preset = {16'h0008, 16'h0008, 16'h0003, 16'h0002, 16'h0002,
                  16'h0002};
        repeat (10) @(negedge clk);
        rst = 1'b0;
        test_base();
        test_up();
        test_down();
        test_updown();
        test_ring();
        test_timers();
        end_of_test();
    end

    // About 80 scans of 4 cycles are needed; this allows about fifteen times that.
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule
